/* File: src/sprp_pkg.sv */
// Constants, register map and state codes for the scratchpad RAM port
`default_nettype none

package sprp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus widths
	localparam int SPRP_AW          = 8;
	localparam int SPRP_DW          = 32;
	localparam int SPRP_TAG_W       = 24;
	localparam int SPRP_PA_W        = 22;
	localparam int SPRP_IIDX_W      = 18;
	localparam int SPRP_DIDX_W      = 16;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] SPRP_OFF_CTRL   = 8'h00;
	localparam logic [7:0] SPRP_OFF_IINDEX = 8'h04;
	localparam logic [7:0] SPRP_OFF_PADDR  = 8'h08;
	localparam logic [7:0] SPRP_OFF_WDATA  = 8'h0C;
	localparam logic [7:0] SPRP_OFF_TAG_LOW_REGISTER  = 8'h10;
	localparam logic [7:0] SPRP_OFF_STATUS = 8'h14;
	localparam logic [7:0] SPRP_OFF_RWORD  = 8'h18;
	localparam logic [7:0] SPRP_OFF_DINDEX = 8'h1C;
	localparam logic [7:0] SPRP_OFF_RTAG   = 8'h20;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int SPRP_CTRL_IREAD   = 0;
	localparam int SPRP_CTRL_ITAGWR  = 1;
	localparam int SPRP_CTRL_IDATAWR = 2;
	localparam int SPRP_CTRL_LOADTAG = 3;
	localparam int SPRP_CTRL_DREAD   = 4;
	localparam int SPRP_ST_BUSY      = 0;
	localparam int SPRP_ST_IHIT      = 1;
	localparam int SPRP_ST_DHIT      = 2;
	localparam int SPRP_ST_IATT      = 3;
	localparam int SPRP_ST_DATT      = 4;
	localparam int SPRP_ST_DONE      = 5;
	localparam int SPRP_ST_REFUSED   = 6;
	localparam int SPRP_ST_WAITLO    = 8;
	localparam int SPRP_PADDR_UNC    = 0;
	localparam int SPRP_PADDR_PALO   = 10;
	localparam int SPRP_IINDEX_LO    = 2;
	localparam int SPRP_DINDEX_LO    = 4;

	////////////////////////////////////////////////////////////////////////
	// Reset values and counter width
	localparam logic [31:0] SPRP_RST_WORD = 32'h0000_0000;
	localparam int          SPRP_WCNT_W   = 8;

	////////////////////////////////////////////////////////////////////////
	// Port sequencer states, one-hot
	typedef enum logic [4:0] {
		SPRP_S_IDLE    = 5'b00001,
		SPRP_S_IREAD   = 5'b00010,
		SPRP_S_ITAGWR  = 5'b00100,
		SPRP_S_IDATAWR = 5'b01000,
		SPRP_S_DREAD   = 5'b10000
	} sprp_state_e;

	// Address decode used by the slave for write enable, error and read data zeroing
	function automatic logic sprp_mapped(input logic [7:0] a);
		sprp_mapped = (a[1:0] == 2'h0) && (a <= SPRP_OFF_RTAG);
	endfunction

endpackage

`default_nettype wire

/* File: src/sprp_bus_fmt.sv */
// Formats the shared write/compare bus and the data-side compare bus
`default_nettype none

module sprp_bus_fmt
	import sprp_pkg::*;
(
	input  wire sprp_state_e                state,
	input  wire logic [SPRP_PA_W-1:0]       pa,
	input  wire logic                       uncacheable,
	input  wire logic [SPRP_TAG_W-1:0]      tag_low,
	input  wire logic [SPRP_DW-1:0]         wdata,
	output logic      [SPRP_DW-1:0]         next_iside_bus,
	output logic      [SPRP_TAG_W-1:0]      next_dside_cmp
);

	////////////////////////////////////////////////////////////////////////
	// Shared bus contents chosen by the operation about to start
	always_comb begin
		unique case (state)
			SPRP_S_IDATAWR: next_iside_bus = wdata;
			SPRP_S_ITAGWR:  next_iside_bus = {8'h00, tag_low};
			default:        next_iside_bus = {8'h00, pa, uncacheable, 1'b0};
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// data-side compare word
	always_comb begin
		next_dside_cmp = {pa, 2'b00};
	end

endmodule

`default_nettype wire

/* File: src/sprp_apb_slave.sv */
// APB slave front end: registered ready, read data and error
`default_nettype none

module sprp_apb_slave
	import sprp_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [SPRP_AW-1:0]     paddr,
	input  wire logic [SPRP_DW-1:0]     rd_word,
	output logic                        pready,
	output logic                        pslverr,
	output logic      [SPRP_DW-1:0]     prdata,
	output logic                        wr_en
);

	logic access;

	// First access cycle waits one beat so pready, pslverr and prdata are flops; wr_en stays combinational
	assign access = psel & penable & ~pready;
	// Write lands at the completing edge only
	assign wr_en  = psel & penable & pready & pwrite & sprp_mapped(paddr);

	////////////////////////////////////////////////////////////////////////
	// One wait state on every transfer
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= access;
			pslverr <= access & ~sprp_mapped(paddr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data sampled in the wait beat; unmapped reads give zero
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prdata <= SPRP_RST_WORD;
		end else if (access) begin
			prdata <= (pwrite || !sprp_mapped(paddr)) ? SPRP_RST_WORD : rd_word;
		end
	end

endmodule

`default_nettype wire

/* File: src/sprp_port.sv */
// Core-side scratchpad RAM port sequencer with APB register file
// Functional notes
// - The array raises wait while a read is unfinished, and the core holds the read until it drops.
// - The core drives one word index, bits 19 to 2, for all instruction-side accesses.
// - One instruction-side read strobe reads tag and data together and qualifies hit and wait.
// - The core pulses the instruction-side tag write strobe to load a new tag.
// - On a data write the shared bus carries the 32-bit word to store.
// - On a tag write the shared bus carries zero byte, PA 31 to 10, lock and valid from tag low.
// - For comparison the shared bus carries zero byte, PA 31 to 10, uncacheable and a zero.
// - The uncacheable flag is high exactly when the physical address is uncacheable.
// - The core pulses the data write strobe to store the shared bus value.
// - The returned 24-bit tag is loaded into tag low on a cache-management operation.
// - The data side has its own tag read strobe that qualifies hit, wait and returned tag.
// - The data-side compare bus is PA 31 to 10 followed by two zero bits.
// - Array responses are used unregistered so an access can finish in one cycle.
//
// Our own choices: the placing of the registers and the APB slave port.
`default_nettype none

module sprp_port
	import sprp_pkg::*;
(
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	// APB register bus
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [SPRP_AW-1:0]         paddr,
	input  wire logic [SPRP_DW-1:0]         pwdata,
	output logic      [SPRP_DW-1:0]         prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Instruction-side scratchpad
	output logic      [19:2]                iside_scratch_index,
	output logic                            iside_scratch_read_strobe,
	output logic                            iside_scratch_tag_write_strobe,
	output logic                            iside_scratch_data_write_strobe,
	output logic      [SPRP_DW-1:0]         iside_scratch_write_compare_bus,
	input  wire logic [SPRP_DW-1:0]         iside_scratch_read_word,
	input  wire logic [SPRP_TAG_W-1:0]      iside_scratch_read_tag,
	input  wire logic                       iside_scratch_hit,
	input  wire logic                       iside_scratch_wait,
	input  wire logic                       iside_scratch_attached,
	// Data-side scratchpad tag path
	output logic      [19:4]                dside_scratch_tag_index,
	output logic                            dside_scratch_tag_read_strobe,
	output logic      [SPRP_TAG_W-1:0]      dside_scratch_compare_bus,
	input  wire logic [SPRP_TAG_W-1:0]      dside_scratch_read_tag,
	input  wire logic                       dside_scratch_hit,
	input  wire logic                       dside_scratch_wait,
	input  wire logic                       dside_scratch_attached
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	sprp_state_e                state;
	sprp_state_e                next_state;
	logic                       wr_en;
	logic [SPRP_DW-1:0]         rd_word;
	logic [SPRP_PA_W-1:0]       pa;
	logic                       uncacheable;
	logic [SPRP_TAG_W-1:0]      tag_low;
	logic [SPRP_DW-1:0]         wdata;
	logic [SPRP_DW-1:0]         read_word;
	logic [SPRP_TAG_W-1:0]      read_tag;
	logic                       ihit;
	logic                       dhit;
	logic                       done;
	logic                       refused;
	logic                       load_tag;
	logic                       iattached;
	logic                       dattached;
	logic                       straps_taken;
	logic [SPRP_WCNT_W-1:0]     wait_count;
	logic [SPRP_DW-1:0]         next_iside_bus;
	logic [SPRP_TAG_W-1:0]      next_dside_cmp;
	logic                       ctrl_wr;
	logic                       idle;
	logic                       start;
	logic                       cmd_refused;
	logic                       iread_done;
	logic                       dread_done;

	assign idle    = (state == SPRP_S_IDLE);
	assign ctrl_wr = wr_en && (paddr == SPRP_OFF_CTRL);

	////////////////////////////////////////////////////////////////////////
	// Bus slave and bus formatting

	sprp_apb_slave u_apb (
		.mclk    (mclk),
		.resetn  (resetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.rd_word (rd_word),
		.pready  (pready),
		.pslverr (pslverr),
		.prdata  (prdata),
		.wr_en   (wr_en)
	);

	sprp_bus_fmt u_fmt (
		.state          (next_state),
		.pa             (pa),
		.uncacheable    (uncacheable),
		.tag_low        (tag_low),
		.wdata          (wdata),
		.next_iside_bus (next_iside_bus),
		.next_dside_cmp (next_dside_cmp)
	);

	////////////////////////////////////////////////////////////////////////
	// Attached straps, caught once after reset release

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			iattached    <= 1'b0;
			dattached    <= 1'b0;
			straps_taken <= 1'b0;
		end else if (!straps_taken) begin
			iattached    <= iside_scratch_attached;
			dattached    <= dside_scratch_attached;
			straps_taken <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command decode and sequencing

	// completion looks straight at the array's wait input
	assign iread_done = (state == SPRP_S_IREAD) && !iside_scratch_wait;
	assign dread_done = (state == SPRP_S_DREAD) && !dside_scratch_wait;

	// Command to an unfitted port is dropped and flagged
	always_comb begin
		start       = 1'b0;
		cmd_refused = 1'b0;
		next_state  = state;
		unique case (state)
			SPRP_S_IDLE: begin
				if (ctrl_wr) begin
					if (pwdata[SPRP_CTRL_IREAD] || pwdata[SPRP_CTRL_ITAGWR]
						|| pwdata[SPRP_CTRL_IDATAWR]) begin
						cmd_refused = !iattached;
						start       = iattached;
					end else if (pwdata[SPRP_CTRL_DREAD]) begin
						cmd_refused = !dattached;
						start       = dattached;
					end
					if (start) begin
						if (pwdata[SPRP_CTRL_IREAD]) begin
							next_state = SPRP_S_IREAD;
						end else if (pwdata[SPRP_CTRL_ITAGWR]) begin
							next_state = SPRP_S_ITAGWR;
						end else if (pwdata[SPRP_CTRL_IDATAWR]) begin
							next_state = SPRP_S_IDATAWR;
						end else begin
							next_state = SPRP_S_DREAD;
						end
					end
				end
			end
			// read stays open until wait drops
			SPRP_S_IREAD: begin
				if (iread_done) begin
					next_state = SPRP_S_IDLE;
				end
			end
			// data-side read closes on its own wait
			SPRP_S_DREAD: begin
				if (dread_done) begin
					next_state = SPRP_S_IDLE;
				end
			end
			// Writes are single-beat, no wait honoured
			SPRP_S_ITAGWR,
			SPRP_S_IDATAWR: begin
				next_state = SPRP_S_IDLE;
			end
			default: begin
				next_state = SPRP_S_IDLE;
			end
		endcase
	end

	// Sequencer state
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= SPRP_S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strobes and shared buses

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			iside_scratch_read_strobe       <= 1'b0;
			iside_scratch_tag_write_strobe  <= 1'b0;
			iside_scratch_data_write_strobe <= 1'b0;
			dside_scratch_tag_read_strobe   <= 1'b0;
		end else begin
			iside_scratch_read_strobe       <= (next_state == SPRP_S_IREAD);
			iside_scratch_tag_write_strobe  <= (next_state == SPRP_S_ITAGWR);
			iside_scratch_data_write_strobe <= (next_state == SPRP_S_IDATAWR);
			dside_scratch_tag_read_strobe   <= (next_state == SPRP_S_DREAD);
		end
	end

	// bus values only change from idle, so held across a stall
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			iside_scratch_write_compare_bus <= SPRP_RST_WORD;
			dside_scratch_compare_bus       <= SPRP_RST_WORD[SPRP_TAG_W-1:0];
		end else if (idle) begin
			iside_scratch_write_compare_bus <= next_iside_bus;
			dside_scratch_compare_bus       <= next_dside_cmp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers, writable only while idle

	// index held steady by the idle guard
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			iside_scratch_index     <= SPRP_RST_WORD[19:2];
			dside_scratch_tag_index <= SPRP_RST_WORD[19:4];
			pa                      <= SPRP_RST_WORD[SPRP_PA_W-1:0];
			uncacheable             <= 1'b0;
			wdata                   <= SPRP_RST_WORD;
		end else if (wr_en && idle) begin
			unique case (paddr)
				SPRP_OFF_IINDEX: iside_scratch_index     <= pwdata[19:2];
				SPRP_OFF_DINDEX: dside_scratch_tag_index <= pwdata[19:4];
				SPRP_OFF_WDATA:  wdata                   <= pwdata;
				// software states cacheability with the address
				SPRP_OFF_PADDR: begin
					pa          <= pwdata[31:SPRP_PADDR_PALO];
					uncacheable <= pwdata[SPRP_PADDR_UNC];
				end
				default: begin
				end
			endcase
		end
	end

	// Load-tag option latched with the read command
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			load_tag <= 1'b0;
		end else if (start) begin
			load_tag <= pwdata[SPRP_CTRL_LOADTAG];
		end
	end

	// tag low from software or from a completed tag read
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tag_low <= SPRP_RST_WORD[SPRP_TAG_W-1:0];
		end else if (iread_done && load_tag) begin
			tag_low <= iside_scratch_read_tag;
		end else if (dread_done && load_tag) begin
			tag_low <= dside_scratch_read_tag;
		end else if (wr_en && idle && (paddr == SPRP_OFF_TAG_LOW_REGISTER)) begin
			tag_low <= pwdata[SPRP_TAG_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read results

	// capture word, tag and hit at instruction-side completion; tag and hit only at data-side completion
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			read_word <= SPRP_RST_WORD;
			read_tag  <= SPRP_RST_WORD[SPRP_TAG_W-1:0];
			ihit      <= 1'b0;
			dhit      <= 1'b0;
		end else if (iread_done) begin
			read_word <= iside_scratch_read_word;
			read_tag  <= iside_scratch_read_tag;
			ihit      <= iside_scratch_hit;
		end else if (dread_done) begin
			read_tag  <= dside_scratch_read_tag;
			dhit      <= dside_scratch_hit;
		end
	end

	// Stall beats of the last command, zero after a write, saturating; helps size the array timing
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wait_count <= '0;
		end else if (start) begin
			wait_count <= '0;
		end else if (((state == SPRP_S_IREAD) && iside_scratch_wait)
			|| ((state == SPRP_S_DREAD) && dside_scratch_wait)) begin
			if (wait_count != {SPRP_WCNT_W{1'b1}}) begin
				wait_count <= wait_count + 1'b1;
			end
		end
	end

	// Sticky flags; a completion in the clearing cycle wins
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			done    <= 1'b0;
			refused <= 1'b0;
		end else begin
			done    <= (done && !ctrl_wr) || (state != SPRP_S_IDLE && next_state == SPRP_S_IDLE);
			refused <= (refused && !ctrl_wr) || cmd_refused;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register read mux

	always_comb begin
		rd_word = SPRP_RST_WORD;
		unique case (paddr)
			SPRP_OFF_IINDEX: rd_word[19:2]               = iside_scratch_index;
			SPRP_OFF_DINDEX: rd_word[19:4]               = dside_scratch_tag_index;
			SPRP_OFF_WDATA:  rd_word                     = wdata;
			SPRP_OFF_TAG_LOW_REGISTER:  rd_word[SPRP_TAG_W-1:0]     = tag_low;
			SPRP_OFF_RWORD:  rd_word                     = read_word;
			SPRP_OFF_RTAG:   rd_word[SPRP_TAG_W-1:0]     = read_tag;
			SPRP_OFF_PADDR: begin
				rd_word[31:SPRP_PADDR_PALO] = pa;
				rd_word[SPRP_PADDR_UNC]     = uncacheable;
			end
			SPRP_OFF_STATUS: begin
				rd_word[SPRP_ST_BUSY]    = !idle;
				rd_word[SPRP_ST_IHIT]    = ihit;
				rd_word[SPRP_ST_DHIT]    = dhit;
				rd_word[SPRP_ST_IATT]    = iattached;
				rd_word[SPRP_ST_DATT]    = dattached;
				rd_word[SPRP_ST_DONE]    = done;
				rd_word[SPRP_ST_REFUSED] = refused;
				rd_word[SPRP_ST_WAITLO +: SPRP_WCNT_W] = wait_count;
			end
			default: begin
			end
		endcase
	end

endmodule

`default_nettype wire

/* File: tb/sprp_port_props.sv */
// Pin-level protocol checks for the scratchpad port
`default_nettype none

module sprp_port_props
	import sprp_pkg::*;
(
	input wire logic                  mclk,
	input wire logic                  resetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pready,
	input wire logic [19:2]           iside_scratch_index,
	input wire logic                  iside_scratch_read_strobe,
	input wire logic                  iside_scratch_tag_write_strobe,
	input wire logic                  iside_scratch_data_write_strobe,
	input wire logic [SPRP_DW-1:0]    iside_scratch_write_compare_bus,
	input wire logic                  iside_scratch_wait,
	input wire logic                  dside_scratch_tag_read_strobe,
	input wire logic [SPRP_TAG_W-1:0] dside_scratch_compare_bus,
	input wire logic                  dside_scratch_wait
);

	////////////////////////////////////////////////////////////////////////
	// One clock domain
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	// Read steps: stalled, then held steady
	sequence s_rd_stalled;
		iside_scratch_read_strobe && iside_scratch_wait;
	endsequence
	sequence s_rd_held;
		iside_scratch_read_strobe && $stable(iside_scratch_index)
			&& $stable(iside_scratch_write_compare_bus);
	endsequence

	property p_rd_hold; s_rd_stalled |=> s_rd_held; endproperty
	property p_rd_end;
		iside_scratch_read_strobe && !iside_scratch_wait |=> !iside_scratch_read_strobe;
	endproperty
	property p_twr_pulse;
		iside_scratch_tag_write_strobe |=> !iside_scratch_tag_write_strobe;
	endproperty
	property p_dwr_pulse;
		iside_scratch_data_write_strobe |=> !iside_scratch_data_write_strobe;
	endproperty
	property p_one_op;
		$onehot0({iside_scratch_read_strobe, iside_scratch_tag_write_strobe,
			iside_scratch_data_write_strobe, dside_scratch_tag_read_strobe});
	endproperty
	property p_cmp_fmt;
		iside_scratch_read_strobe |-> iside_scratch_write_compare_bus[31:24] == 8'h00
			&& iside_scratch_write_compare_bus[0] == 1'b0;
	endproperty
	property p_twr_fmt;
		iside_scratch_tag_write_strobe |-> iside_scratch_write_compare_bus[31:24] == 8'h00;
	endproperty
	property p_dcmp_fmt;
		dside_scratch_tag_read_strobe |-> dside_scratch_compare_bus[1:0] == 2'h0;
	endproperty
	property p_d_hold;
		dside_scratch_tag_read_strobe && dside_scratch_wait
			|=> dside_scratch_tag_read_strobe && $stable(dside_scratch_compare_bus);
	endproperty
	property p_d_end;
		dside_scratch_tag_read_strobe && !dside_scratch_wait
			|=> !dside_scratch_tag_read_strobe;
	endproperty
	// Exactly one wait beat per bus access
	property p_apb_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty

	a_rd_hold: assert property (p_rd_hold)
		else $error("read moved while stalled");
	a_rd_end: assert property (p_rd_end)
		else $error("read strobe too long");
	a_twr_pulse: assert property (p_twr_pulse)
		else $error("tag write strobe too long");
	a_dwr_pulse: assert property (p_dwr_pulse)
		else $error("data write strobe too long");
	a_one_op: assert property (p_one_op)
		else $error("two scratchpad strobes at once");
	a_cmp_fmt: assert property (p_cmp_fmt)
		else $error("compare word framing wrong");
	a_twr_fmt: assert property (p_twr_fmt)
		else $error("tag write framing wrong");
	a_dcmp_fmt: assert property (p_dcmp_fmt)
		else $error("data compare low bits set");
	a_d_hold: assert property (p_d_hold)
		else $error("data read moved while stalled");
	a_d_end: assert property (p_d_end)
		else $error("data strobe too long");
	a_apb_wait: assert property (p_apb_wait)
		else $error("bus wait beat wrong");

endmodule

bind sprp_port sprp_port_props u_props (.mclk, .resetn, .psel, .penable, .pready,
	.iside_scratch_index, .iside_scratch_read_strobe, .iside_scratch_tag_write_strobe,
	.iside_scratch_data_write_strobe, .iside_scratch_write_compare_bus, .iside_scratch_wait,
	.dside_scratch_tag_read_strobe, .dside_scratch_compare_bus, .dside_scratch_wait);

`default_nettype wire

/* File: tb/sprp_array_model.sv */
// Behavioural scratchpad array with tag compare and stall
`default_nettype none

module sprp_array_model #(
	parameter logic [23:0] DTAG = 24'hABCD03
) (
	input  wire logic        mclk,
	input  wire logic [3:0]  stall_n,
	input  wire logic [19:2] idx,
	input  wire logic        rd,
	input  wire logic        tw,
	input  wire logic        dw,
	input  wire logic [31:0] bus,
	input  wire logic        ds,
	input  wire logic [23:0] cmp,
	output logic      [31:0] word,
	output logic      [23:0] itag_out,
	output logic             ihit,
	output logic             iwait,
	output logic      [23:0] dtag_out,
	output logic             dhit,
	output logic             dwait
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [31:0] mem [16];
	logic [23:0] itag = 24'h000000;
	logic [3:0]  cnt = 4'h0;

	always @(posedge mclk) begin
		if (dw) mem[idx[5:2]] <= bus;
		if (tw) itag <= bus[23:0];
		cnt <= (rd || ds) ? cnt + 4'h1 : 4'h0;
	end

	assign iwait = rd && (cnt < stall_n);
	assign dwait = ds && (cnt < stall_n);
	// hit on a tag match; only the instruction side also needs the valid bit
	assign ihit = rd && itag[0] && (bus[23:2] == itag[23:2]);
	assign dhit = ds && (cmp[23:2] == DTAG[23:2]);
	assign word     = (rd && !iwait) ? mem[idx[5:2]] : ~mem[idx[5:2]];
	assign itag_out = (rd && !iwait) ? itag : ~itag;
	assign dtag_out = (ds && !dwait) ? DTAG : ~DTAG;
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the scratchpad port
`default_nettype none

`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
	$display("unexpected %s exp %h got %h", nm, e, a); end end

module testbench;
	import sprp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [23:0] DTAG = 24'hABCD03;
	logic mclk, resetn, psel, penable, pwrite, pready, pslverr, erq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdq, tw_bus, dw_bus, rd_bus;
	logic [19:2] iside_scratch_index, dw_idx;
	logic iside_scratch_read_strobe, iside_scratch_tag_write_strobe;
	logic iside_scratch_data_write_strobe, iside_scratch_hit, iside_scratch_wait;
	logic [31:0] iside_scratch_write_compare_bus, iside_scratch_read_word;
	logic [23:0] iside_scratch_read_tag, dside_scratch_read_tag, dside_scratch_compare_bus, d_cmp;
	logic [19:4] dside_scratch_tag_index;
	logic dside_scratch_tag_read_strobe, dside_scratch_hit, dside_scratch_wait;
	logic [3:0] stall_n;
	int bad_count, checked;
	wire logic iside_scratch_attached = 1'b1;
	wire logic dside_scratch_attached = 1'b1;

	sprp_port DUT (.*);

	sprp_array_model #(.DTAG(DTAG)) u_array (.mclk, .stall_n, .idx(iside_scratch_index),
		.rd(iside_scratch_read_strobe), .tw(iside_scratch_tag_write_strobe),
		.dw(iside_scratch_data_write_strobe), .bus(iside_scratch_write_compare_bus),
		.ds(dside_scratch_tag_read_strobe), .cmp(dside_scratch_compare_bus),
		.word(iside_scratch_read_word), .itag_out(iside_scratch_read_tag),
		.ihit(iside_scratch_hit), .iwait(iside_scratch_wait), .dtag_out(dside_scratch_read_tag),
		.dhit(dside_scratch_hit), .dwait(dside_scratch_wait));

	////////////////////////////////////////////////////////////////////////
	// Clock and strobe-time bus capture
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (iside_scratch_tag_write_strobe) tw_bus <= iside_scratch_write_compare_bus;
		if (iside_scratch_data_write_strobe) begin
			dw_bus <= iside_scratch_write_compare_bus;
			dw_idx <= iside_scratch_index;
		end
		if (iside_scratch_read_strobe) rd_bus <= iside_scratch_write_compare_bus;
		if (dside_scratch_tag_read_strobe) d_cmp <= dside_scratch_compare_bus;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One bus access, held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge mclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk) n++; while (pready !== 1'b1 && n < 20);
		{rdq, erq} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		if (pready !== 1'b1) begin
			bad_count++;
			$display("unexpected bus hang");
			close_out();
		end
	endtask

	// Command, then bounded status poll
	task automatic op(input logic [31:0] cmd);
		int n = 0;
		apb(1'b1, SPRP_OFF_CTRL, cmd);
		do begin
			apb(1'b0, SPRP_OFF_STATUS, 32'h0);
			n++;
		end while ({rdq[SPRP_ST_DONE], rdq[SPRP_ST_BUSY]} !== 2'b10 && n < 30);
		if (n >= 30) begin
			bad_count++;
			$display("unexpected op hang");
			close_out();
		end
	endtask

	task automatic t_regs();
		apb(1'b0, SPRP_OFF_STATUS, 32'h0);
		`CHK("status after reset", 32'h0000_0018, rdq)
		apb(1'b0, 8'h24, 32'h0);
		`CHK("unmapped error", 1'b1, erq)
		`CHK("unmapped data", 32'h0, rdq)
		$display("registers test done");
	endtask

	task automatic t_write(input logic [17:0] ix, input logic [31:0] w);
		apb(1'b1, SPRP_OFF_IINDEX, {12'h000, ix, 2'b00});
		apb(1'b1, SPRP_OFF_WDATA, w);
		op(32'h4);
		`CHK("data write word", w, dw_bus)
		`CHK("index", ix, dw_idx)
		$display("data write test done");
	endtask

	task automatic t_tag(input logic [23:0] tg);
		apb(1'b1, SPRP_OFF_TAG_LOW_REGISTER, {8'h00, tg});
		op(32'h2);
		`CHK("tag write word", {8'h00, tg}, tw_bus)
		$display("tag write test done");
	endtask

	task automatic t_read(input logic [21:0] pa, logic unc, logic [3:0] st,
		logic hit, logic [31:0] w, logic [23:0] tg);
		stall_n <= st;
		apb(1'b1, SPRP_OFF_TAG_LOW_REGISTER, 32'h0);
		apb(1'b1, SPRP_OFF_PADDR, {pa, 9'h000, unc});
		op(32'h9);
		`CHK("read compare word", {8'h00, pa, unc, 1'b0}, rd_bus)
		`CHK("hit flag", hit, rdq[SPRP_ST_IHIT])
		`CHK("wait beats", {4'h0, st}, rdq[15:8])
		apb(1'b0, SPRP_OFF_RWORD, 32'h0);
		`CHK("read word", w, rdq)
		apb(1'b0, SPRP_OFF_TAG_LOW_REGISTER, 32'h0);
		`CHK("loaded tag", {8'h00, tg}, rdq)
		$display("read test done");
	endtask

	task automatic t_dread();
		stall_n <= 4'h2;
		apb(1'b1, SPRP_OFF_DINDEX, 32'h0000_0150);
		apb(1'b1, SPRP_OFF_PADDR, {DTAG[23:2], 10'h000});
		op(32'h18);
		`CHK("data side hit", 1'b1, rdq[SPRP_ST_DHIT])
		`CHK("data side compare", {DTAG[23:2], 2'b00}, d_cmp)
		`CHK("data side index", 16'h0015, dside_scratch_tag_index)
		apb(1'b0, SPRP_OFF_RTAG, 32'h0);
		`CHK("data side tag", {8'h00, DTAG}, rdq)
		$display("data side test done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata, stall_n} = 48'h0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		t_regs();
		t_write(18'h2AAA5, 32'hC0DE_1234);
		t_tag(24'h5A5A5B);
		t_read(22'h169696, 1'b0, 4'h0, 1'b1, 32'hC0DE_1234, 24'h5A5A5B);
		// Uncacheable miss, long stall
		t_read(22'h000001, 1'b1, 4'h3, 1'b0, 32'hC0DE_1234, 24'h5A5A5B);
		t_dread();
		close_out();
	end
endmodule

`default_nettype wire
